// file: design/reader_pkg.sv
// Notes on behaviour
// - sleep request set, deep sleep select clear: idle mode, oscillator keeps running.
// - sleep request and deep sleep select both set: deep sleep, oscillator stopped.
// - data rising while serial clock high starts an exchange and resets the decoder.
// - command bits arrive most significant bit first and are assembled that way.
// - data in and data out are valid while the serial clock is high.
// - filter select high filters clock and data inputs; low uses them unfiltered.
// - leading bits 1,1,1 enter tag receive mode and stream tag data out.
// - tag receive mode ends on a serial clock rising edge.
// - command 0001 plus four-bit length enters tag write mode, storing the length.
// - write with length zero: data in high turns drivers off, low on.
// - write with length N: drivers off from next data rise for N times 8 us.
// - tag write mode ends at once on a serial clock rising edge.
// - leading bits 1,1,0 enter tag write mode after third bit, stored length.
// - stored pulse length is zero until the first timed write command.
// - command with only bit 3 set returns the measured antenna phase.
// - phase answer byte is two zero bits then six-bit unsigned phase.
// - command with top bits 1,0 loads low six bits as sampling time.
// - command with only bit 1 set returns stored sampling time after two zeros.
// - leading bits 0,1 write four low bits into page chosen by next two bits.
`default_nettype none

package reader_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned PULSE_UNIT_NS = 8000;
  localparam int unsigned PULSE_UNIT_CYC = PULSE_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned FILTER_STABLE_CYC = 3;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned BYTE_W = 8;

  localparam logic [2:0] CMD_READ_TAG = 3'h7;
  localparam logic [2:0] CMD_WRITE_SHORT = 3'h6;
  localparam logic [3:0] CMD_WRITE_N = 4'h1;
  localparam logic [7:0] CMD_READ_PHASE = 8'h08;
  localparam logic [7:0] CMD_SAMPLE_READ = 8'h02;
  localparam logic [1:0] CMD_SET_SAMPLE = 2'h2;
  localparam logic [1:0] CMD_SET_PAGE = 2'h1;

  localparam logic [3:0] PAGE0_RESET = 4'h8;
  localparam logic [3:0] PAGE_RESET = 4'h0;
  localparam logic [5:0] SAMPLE_RESET = 6'h00;
  localparam logic [3:0] PULSE_RESET = 4'h0;
  localparam int unsigned POWER_PAGE = 1;
  localparam int unsigned SLEEP_BIT = 2;
  localparam int unsigned DEEP_BIT = 3;

  typedef struct packed {
    logic sclk;
    logic din;
  } serial_pins_type;

  typedef struct packed {
    logic idle_mode;
    logic deep_sleep;
  } power_type;

  typedef enum logic [2:0] {
    st_wait_init,
    st_command,
    st_read_tag,
    st_write_tag,
    st_respond
  } state_type;

  function automatic logic [7:0] pad_six(input logic [5:0] v);
    return {2'h0, v};
  endfunction

endpackage

`default_nettype wire

// file: design/input_filter.sv
`default_nettype none

module input_filter (
  input wire logic clk,
  input wire logic reset,
  input wire reader_pkg::serial_pins_type pins_async,
  input wire logic filter_select,
  output var reader_pkg::serial_pins_type pins_clean
);
  import reader_pkg::*;

  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] out_r;
  logic [1:0] cnt_r [2];
  logic mode1_r;
  logic mode2_r;

  assign pins_clean = out_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      mode1_r <= 1'b0;
      mode2_r <= 1'b0;
    end else begin
      s1_r <= pins_async;
      s2_r <= s1_r;
      mode1_r <= filter_select;
      mode2_r <= mode1_r;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (reset) begin
        out_r[i] <= 1'b0;
        cnt_r[i] <= 2'h0;
      end else if (!mode2_r || s2_r[i] == out_r[i]) begin
        out_r[i] <= s2_r[i];
        cnt_r[i] <= 2'h0;
      end else if (cnt_r[i] == 2'(FILTER_STABLE_CYC - 1)) begin
        out_r[i] <= s2_r[i];
        cnt_r[i] <= 2'h0;
      end else begin
        cnt_r[i] <= cnt_r[i] + 2'h1;
      end
    end
  end

  filter_stable_a: assert property (@(posedge clk) disable iff (reset)
    $rose(out_r[0]) && $past(mode2_r, 1) && $past(mode2_r, 3)
      |-> $past(s2_r[0], 1) && $past(s2_r[0], 2) && $past(s2_r[0], 3))
    else $error("filtered data changed before input was stable");

endmodule

`default_nettype wire

// file: design/byte_fifo.sv
`default_nettype none

module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;

  wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire empty = (wr_r == rd_r);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_r + (AW + 1)'(push);
      rd_r <= rd_r + (AW + 1)'(pop);
    end
  end

endmodule

`default_nettype wire

// file: design/rfid_serial_command.sv
`default_nettype none

module rfid_serial_command (
  input wire logic clk,
  input wire logic reset,
  input wire reader_pkg::serial_pins_type pins_async,
  input wire logic filter_select,
  input wire logic tag_stream_async,
  input wire logic [5:0] phase_value,
  output logic dout_out,
  output logic dout_oe,
  output logic driver_off,
  output logic tag_read_mode,
  output logic tag_write_mode,
  output logic [5:0] sample_delay,
  output logic [15:0] config_pages,
  output var reader_pkg::power_type power_state
);
  import reader_pkg::*;

  function automatic logic [11:0] pulse_cycles(input logic [3:0] n);
    return 12'(n * PULSE_UNIT_CYC);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // input conditioning and edge detection

  serial_pins_type pins_f;
  logic sclk_prev_r;
  logic din_prev_r;
  logic tag_s1_r;
  logic tag_s2_r;

  input_filter u_filter (
    .clk(clk),
    .reset(reset),
    .pins_async(pins_async),
    .filter_select(filter_select),
    .pins_clean(pins_f)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_prev_r <= 1'b0;
      din_prev_r <= 1'b0;
      tag_s1_r <= 1'b0;
      tag_s2_r <= 1'b0;
    end else begin
      sclk_prev_r <= pins_f.sclk;
      din_prev_r <= pins_f.din;
      tag_s1_r <= tag_stream_async;
      tag_s2_r <= tag_s1_r;
    end
  end

  wire sclk_rise = pins_f.sclk && !sclk_prev_r;
  wire sclk_fall = !pins_f.sclk && sclk_prev_r;
  wire din_rise = pins_f.din && !din_prev_r;
  // clock must have been high already, so a clock rise is never taken for it
  wire init_seen = din_rise && pins_f.sclk && sclk_prev_r;

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  state_type state_r;
  state_type state_nxt;
  logic [7:0] shift_r;
  logic [2:0] bits_r;
  logic [3:0] pulse_len_r;
  logic [5:0] sample_r;
  logic [3:0] pages_r [4];

  wire in_cmd = (state_r == st_command) && !init_seen;
  wire [7:0] next_byte = {shift_r[6:0], pins_f.din};
  wire take_bit = in_cmd && sclk_rise;
  wire third = take_bit && bits_r == 3'h2;
  wire full = take_bit && bits_r == 3'h7;
  wire is_read_tag = third && next_byte[2:0] == CMD_READ_TAG;
  wire is_write_short = third && next_byte[2:0] == CMD_WRITE_SHORT;
  wire wr_n = full && next_byte[7:4] == CMD_WRITE_N;
  wire set_sample = full && next_byte[7:6] == CMD_SET_SAMPLE;
  wire set_page = full && next_byte[7:6] == CMD_SET_PAGE;
  wire rd_phase = full && next_byte == CMD_READ_PHASE;
  wire rd_sample = full && next_byte == CMD_SAMPLE_READ;
  wire resp_done;

  always_comb begin
    state_nxt = state_r;
    if (init_seen) begin
      state_nxt = st_command;
    end else begin
      case (state_r)
        st_command: begin
          if (is_read_tag) begin
            state_nxt = st_read_tag;
          end else if (is_write_short || wr_n) begin
            state_nxt = st_write_tag;
          end else if (rd_phase || rd_sample) begin
            state_nxt = st_respond;
          end else if (full) begin
            state_nxt = st_wait_init;
          end
        end
        st_read_tag: begin
          if (sclk_rise) begin
            state_nxt = st_wait_init;
          end
        end
        st_write_tag: begin
          if (sclk_rise) begin
            state_nxt = st_wait_init;
          end
        end
        st_respond: begin
          if (resp_done) begin
            state_nxt = st_wait_init;
          end
        end
        st_wait_init: state_nxt = st_wait_init;
        default: state_nxt = st_wait_init;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= st_wait_init;
      shift_r <= 8'h00;
      bits_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (init_seen) begin
        shift_r <= 8'h00;
        bits_r <= 3'h0;
      end else if (take_bit) begin
        shift_r <= next_byte;
        bits_r <= bits_r + 3'h1;
      end
    end
  end

  // only timed write, sampling time and page writes touch settings
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_len_r <= PULSE_RESET;
      sample_r <= SAMPLE_RESET;
      pages_r[0] <= PAGE0_RESET;
      for (int i = 1; i < 4; i++) begin
        pages_r[i] <= PAGE_RESET;
      end
    end else begin
      if (wr_n) begin
        pulse_len_r <= next_byte[3:0];
      end
      if (set_sample) begin
        sample_r <= next_byte[5:0];
      end
      if (set_page) begin
        pages_r[next_byte[5:4]] <= next_byte[3:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // answers go through the fifo; the shifter waits while it is empty

  logic push_valid_r;
  logic [7:0] push_data_r;
  logic push_ready;
  logic pop_valid;
  logic [7:0] pop_data;
  logic [7:0] tx_r;
  logic [3:0] tx_bits_r;

  wire in_resp = (state_r == st_respond) && !init_seen;
  wire pop = in_resp && sclk_fall && tx_bits_r == 4'h0 && pop_valid;
  assign resp_done = in_resp && sclk_fall && tx_bits_r == 4'h1;

  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_valid_r),
    .in_data(push_data_r),
    .in_ready(push_ready),
    .out_valid(pop_valid),
    .out_data(pop_data),
    .out_ready(pop)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      push_valid_r <= 1'b0;
      push_data_r <= 8'h00;
    end else if (rd_phase && !push_valid_r) begin
      push_valid_r <= 1'b1;
      push_data_r <= pad_six(phase_value);
    end else if (rd_sample && !push_valid_r) begin
      push_valid_r <= 1'b1;
      push_data_r <= pad_six(sample_r);
    end else if (push_ready) begin
      push_valid_r <= 1'b0;
    end
  end

  // a new bit appears on the clock fall, so it is settled before the rise
  always_ff @(posedge clk) begin
    if (reset || !in_resp) begin
      tx_r <= 8'h00;
      tx_bits_r <= 4'h0;
    end else if (pop) begin
      tx_r <= pop_data;
      tx_bits_r <= 4'h8;
    end else if (sclk_fall && tx_bits_r != 4'h0) begin
      tx_r <= {tx_r[6:0], 1'b0};
      tx_bits_r <= tx_bits_r - 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // driver control for tag write

  logic [11:0] pulse_cnt_r;
  wire in_write = (state_nxt == st_write_tag) && (state_r == st_write_tag);
  wire timed = pulse_len_r != PULSE_RESET;
  wire start = in_write && timed && din_rise && pulse_cnt_r == 12'h000;

  always_ff @(posedge clk) begin
    if (reset || !in_write) begin
      pulse_cnt_r <= 12'h000;
    end else if (start) begin
      pulse_cnt_r <= pulse_cycles(pulse_len_r);
    end else if (pulse_cnt_r != 12'h000) begin
      pulse_cnt_r <= pulse_cnt_r - 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs

  wire dout_level = (state_r == st_read_tag) ? tag_s2_r :
                    (state_r == st_respond && tx_bits_r != 4'h0) ? tx_r[7] : 1'b1;
  wire drv_nxt = !in_write ? 1'b0 :
                 !timed ? pins_f.din :
                 (start || pulse_cnt_r > 12'h001);
  wire sleep_req = pages_r[POWER_PAGE][SLEEP_BIT];
  wire deep_sel = pages_r[POWER_PAGE][DEEP_BIT];

  assign sample_delay = sample_r;
  assign config_pages = {pages_r[3], pages_r[2], pages_r[1], pages_r[0]};

  always_ff @(posedge clk) begin
    if (reset) begin
      dout_out <= 1'b0;
      dout_oe <= 1'b0;
      driver_off <= 1'b0;
      tag_read_mode <= 1'b0;
      tag_write_mode <= 1'b0;
      power_state <= '0;
    end else begin
      dout_out <= 1'b0;
      dout_oe <= !dout_level;
      driver_off <= drv_nxt;
      tag_read_mode <= state_nxt == st_read_tag;
      tag_write_mode <= state_nxt == st_write_tag;
      power_state.idle_mode <= sleep_req && !deep_sel;
      power_state.deep_sleep <= sleep_req && deep_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  init_resets_decoder_a: assert property (@(posedge clk) disable iff (reset)
    init_seen |=> state_r == st_command && bits_r == 3'h0)
    else $error("initialisation did not reset the decoder");

  msb_first_shift_a: assert property (@(posedge clk) disable iff (reset)
    take_bit |=> shift_r[0] == $past(pins_f.din) && shift_r[7:1] == $past(shift_r[6:0]))
    else $error("command bit not shifted in msb first");

  read_tag_entry_a: assert property (@(posedge clk) disable iff (reset)
    is_read_tag |=> tag_read_mode ##1 (dout_oe == !$past(tag_s2_r) || !tag_read_mode))
    else $error("tag receive mode not entered or not streaming");

  read_tag_exit_a: assert property (@(posedge clk) disable iff (reset)
    state_r == st_read_tag && sclk_rise && !init_seen |=> !tag_read_mode)
    else $error("tag receive mode kept after clock rise");

  write_tag_exit_a: assert property (@(posedge clk) disable iff (reset)
    tag_write_mode && sclk_rise && !init_seen |=> !tag_write_mode ##1 !driver_off)
    else $error("tag write mode kept after clock rise");

  short_write_entry_a: assert property (@(posedge clk) disable iff (reset)
    is_write_short |=> tag_write_mode && pulse_len_r == $past(pulse_len_r))
    else $error("short write did not enter tag write mode");

  transparent_drive_a: assert property (@(posedge clk) disable iff (reset)
    in_write && !timed |=> driver_off == $past(pins_f.din))
    else $error("transparent drive does not follow data input");

  timed_pulse_a: assert property (@(posedge clk) disable iff (reset)
    start && !sclk_rise |=> driver_off && pulse_cnt_r == pulse_cycles($past(pulse_len_r)))
    else $error("timed pulse not started with the right length");

  sample_store_a: assert property (@(posedge clk) disable iff (reset)
    set_sample |=> sample_delay == $past(next_byte[5:0]))
    else $error("sampling time not stored");

  unknown_ignored_a: assert property (@(posedge clk) disable iff (reset)
    full && !(wr_n || set_sample || set_page || rd_phase || rd_sample)
      |=> $stable(sample_r) && $stable(pulse_len_r) && state_r == st_wait_init)
    else $error("unknown command changed state or settings");

  phase_answer_a: assert property (@(posedge clk) disable iff (reset)
    rd_phase && !push_valid_r |=> push_valid_r && push_data_r == {2'h0, $past(phase_value)})
    else $error("phase answer byte wrong");

  power_mode_a: assert property (@(posedge clk) disable iff (reset)
    ##1 (power_state.deep_sleep == ($past(sleep_req) && $past(deep_sel)))
      && (power_state.idle_mode == ($past(sleep_req) && !$past(deep_sel))))
    else $error("power mode outputs wrong");

endmodule

`default_nettype wire

// file: test/host_model.sv
`default_nettype none

module host_model (
  input wire logic clk,
  input wire logic dout_line,
  output var reader_pkg::serial_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import reader_pkg::*;

  // half period of the link clock in device clocks; 4 gives the 320 ns link period
  int half = 4;

  initial pins = '{sclk: 1'b0, din: 1'b0};

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic init();
    pins.din = 1'b0;
    hold(half);
    pins.sclk = 1'b1;
    hold(half);
    pins.din = 1'b1;
    hold(half);
  endtask

  // data moves a cycle after sclk falls, so it never races the falling clock
  task automatic send(input logic [7:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      pins.sclk = 1'b0;
      hold(1);
      pins.din = v[i];
      hold(half - 1);
      pins.sclk = 1'b1;
      hold(half);
    end
  endtask

  task automatic recv(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      pins.sclk = 1'b0;
      hold(half);
      pins.sclk = 1'b1;
      hold(half);
      v[i] = dout_line;
    end
    pins.sclk = 1'b0;
  endtask

  task automatic drop();
    pins.sclk = 1'b0;
    hold(half);
  endtask

  task automatic set_din(input logic v);
    pins.din = v;
  endtask

  task automatic leave();
    pins.sclk = 1'b1;
    hold(half);
    pins.sclk = 1'b0;
    pins.din = 1'b0;
    hold(half);
  endtask

  // one-cycle spike, shorter than the filter window
  task automatic glitch();
    drop();
    pins.sclk = 1'b1;
    hold(1);
    drop();
  endtask
endmodule

`default_nettype wire

// file: test/tb_top.sv
`default_nettype none

`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin failures++; \
  $display("FAIL %s expected %h seen %h", nm, ex, gt); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import reader_pkg::*;

  logic clk;
  logic reset;
  logic filter_select;
  logic tag_stream_async;
  logic [5:0] phase_value;
  serial_pins_type pins;
  logic dout_out;
  logic dout_oe;
  logic driver_off;
  logic tag_read_mode;
  logic tag_write_mode;
  logic [5:0] sample_delay;
  logic [15:0] config_pages;
  power_type power_state;
  wire dout_line;
  int failures = 0;
  int checks = 0;
  logic [7:0] got;
  logic [15:0] pages;

  // open drain with pull-up: a released line reads high
  assign dout_line = dout_oe ? dout_out : 1'b1;

  rfid_serial_command dut_u (
    .clk(clk),
    .reset(reset),
    .pins_async(pins),
    .filter_select(filter_select),
    .tag_stream_async(tag_stream_async),
    .phase_value(phase_value),
    .dout_out(dout_out),
    .dout_oe(dout_oe),
    .driver_off(driver_off),
    .tag_read_mode(tag_read_mode),
    .tag_write_mode(tag_write_mode),
    .sample_delay(sample_delay),
    .config_pages(config_pages),
    .power_state(power_state)
  );

  host_model host_u (
    .clk(clk),
    .dout_line(dout_line),
    .pins(pins)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic end_test(input string nm);
    $display("test %s done, failures so far %0d", nm, failures);
  endtask

  task automatic cmd(input logic [7:0] v, input int n);
    host_u.init();
    host_u.send(v, n);
    host_u.hold(8);
  endtask

  task automatic rd(input logic [7:0] c, output logic [7:0] v);
    cmd(c, 8);
    host_u.recv(v);
  endtask

  // counts driver-off cycles after a din rise; edge latency cancels out
  task automatic measure(input int ex);
    int n;
    n = 0;
    // the command's last bit may have left din high; a fresh rise is needed
    host_u.set_din(1'b0);
    host_u.hold(8);
    host_u.set_din(1'b1);
    repeat (ex + 50) begin
      @(negedge clk);
      if (driver_off === 1'b1) n++;
    end
    `CHK("pulse_in_range", 1'b1, (n >= ex - 2) && (n <= ex + 2))
    host_u.set_din(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 30000);
    failures++;
    $display("FAIL watchdog expected done seen hang");
    conclude();
  end

  initial begin
    reset = 1'b1;
    filter_select = 1'b0;
    tag_stream_async = 1'b0;
    phase_value = 6'h35;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("pages", 16'h0008, config_pages)
    `CHK("sample", 6'h00, sample_delay)
    `CHK("drv", 1'b0, driver_off)
    `CHK("oe", 1'b0, dout_oe)
    `CHK("power", 2'b00, power_state)
    end_test("reset");

    cmd(8'h06, 3);
    `CHK("write_mode", 1'b1, tag_write_mode)
    host_u.drop();
    host_u.set_din(1'b1);
    host_u.hold(8);
    `CHK("transp_off", 1'b1, driver_off)
    host_u.set_din(1'b0);
    host_u.hold(8);
    `CHK("transp_on", 1'b0, driver_off)
    host_u.leave();
    `CHK("write_end", 1'b0, tag_write_mode)
    end_test("short_write");

    cmd(8'h05, 3);
    cmd(8'had, 8);
    `CHK("sample", 6'h2d, sample_delay)
    rd(CMD_SAMPLE_READ, got);
    `CHK("sample_read", 8'h2d, got)
    rd(CMD_READ_PHASE, got);
    `CHK("phase_read", 8'h35, got)
    phase_value = 6'h0a;
    rd(CMD_READ_PHASE, got);
    `CHK("phase_read2", 8'h0a, got)
    end_test("readback");

    for (int k = 0; k < 2; k++) begin
      cmd(k == 0 ? 8'h11 : 8'h1f, 8);
      `CHK("write_n_mode", 1'b1, tag_write_mode)
      host_u.drop();
      measure((k == 0 ? 1 : 15) * PULSE_UNIT_CYC);
      host_u.leave();
      `CHK("write_n_end", 1'b0, tag_write_mode)
    end
    cmd(8'h06, 3);
    host_u.drop();
    measure(15 * PULSE_UNIT_CYC);
    host_u.leave();
    end_test("timed_write");

    cmd(8'h07, 3);
    `CHK("read_mode", 1'b1, tag_read_mode)
    host_u.drop();
    tag_stream_async = 1'b1;
    host_u.hold(8);
    `CHK("stream_hi", 1'b1, dout_line)
    tag_stream_async = 1'b0;
    host_u.hold(8);
    `CHK("stream_lo", 1'b0, dout_line)
    host_u.leave();
    `CHK("read_end", 1'b0, tag_read_mode)
    end_test("read_tag");

    pages = 16'h0008;
    for (int p = 0; p < 4; p++) begin
      cmd({2'b01, p[1:0], 4'(p + 9)}, 8);
      pages[p * 4 +: 4] = 4'(p + 9);
    end
    `CHK("pages", pages, config_pages)
    cmd(8'h54, 8);
    `CHK("idle", 2'b10, power_state)
    cmd(8'h5c, 8);
    `CHK("deep", 2'b01, power_state)
    cmd(8'h50, 8);
    `CHK("awake", 2'b00, power_state)
    end_test("pages");

    cmd(8'h04, 8);
    host_u.send(8'hbf, 8);
    host_u.hold(8);
    `CHK("unknown_sample", 6'h2d, sample_delay)
    `CHK("unknown_pages", 16'hcb09, config_pages)
    end_test("unknown");

    filter_select = 1'b1;
    host_u.half = 16;
    host_u.hold(20);
    host_u.init();
    host_u.send(8'h09, 4);
    host_u.glitch();
    host_u.send(8'h0a, 4);
    host_u.hold(20);
    `CHK("filtered", 6'h1a, sample_delay)
    end_test("filter");
    conclude();
  end
endmodule

`default_nettype wire
